// file: fswp_status.sv
// Status register and write-protect logic behind the SPI pins.
`timescale 1ns/1ps
module fswp_status
    import fswp_pkg::*;
(
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    input  wire logic                    clk_en,
    input  wire logic                    power_cycle,
    input  wire logic                    spi_clk,
    input  wire logic                    spi_cs_n,
    input  wire logic                    spi_di,
    input  wire logic                    write_protect_n,
    input  wire logic                    busy_in,
    output logic                         spi_do,
    output logic                         spi_do_oe,
    output logic [7:0]                   status_first_q,
    output logic [7:0]                   status_config_second_q,
    output logic [7:0]                   status_config_third_q,
    output logic [2:0]                   security_lock_q,
    output logic                         quad_data_en_q,
    output logic                         hold_en_q,
    output logic [1:0]                   drive_strength_q,
    output logic                         block_locks_q,
    output logic                         array_write_q,
    output logic                         array_reject_q,
    output logic [FSWP_ADDR_W-1:0]       array_addr_q
);

    logic [2:0]  clk_sync_q;
    logic [1:0]  cs_sync_q;
    logic [1:0]  di_sync_q;
    logic [1:0]  wp_sync_q;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_n;
    logic        di;
    logic        wp_n;
    fswp_state_e state_q;
    logic [2:0]  bit_cnt_q;
    logic [7:0]  shift_q;
    logic [7:0]  opcode_q;
    logic [4:0]  byte_cnt_q;
    logic [7:0]  tx_q;
    logic [FSWP_ADDR_W-1:0] addr_q;
    logic        prefix1_q;
    logic        prefix_armed_q;
    logic        otp_lock_q;
    logic        sus_set;
    logic        sus_clr;
    logic        byte_done;
    logic        cmd_end;
    logic        sr_write_ok;
    logic        region_prot;
    logic [FSWP_ADDR_W-1:0] hi_addr;

    // All pins pass two flops; the link clock keeps a third for edges.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            clk_sync_q <= '0;
            cs_sync_q  <= 2'h3;
            di_sync_q  <= '0;
            wp_sync_q  <= 2'h3;
        end
        else if (clk_en)
        begin
            clk_sync_q <= {clk_sync_q[1:0], spi_clk};
            cs_sync_q  <= {cs_sync_q[0], spi_cs_n};
            di_sync_q  <= {di_sync_q[0], spi_di};
            wp_sync_q  <= {wp_sync_q[0], write_protect_n};
        end
    end

    assign sclk_rise = clk_en && clk_sync_q[1] && !clk_sync_q[2];
    assign sclk_fall = clk_en && !clk_sync_q[1] && clk_sync_q[2];
    assign cs_n      = cs_sync_q[1];
    assign di        = di_sync_q[1];
    assign wp_n      = wp_sync_q[1];
    assign byte_done = sclk_rise && (bit_cnt_q == 3'h7);
    // Write commands only act when chip select rises on a byte boundary.
    assign cmd_end   = clk_en && cs_n && (state_q != FSWP_IDLE) &&
                       (bit_cnt_q == 3'h0);

    // Pin gating is dropped in quad mode; lock-down beats everything.
    always_comb
    begin
        sr_write_ok = status_first_q[FSWP_S1_WEL]; // RL1
        if (status_config_second_q[FSWP_S2_SRL] || otp_lock_q)
            sr_write_ok = 1'b0; // RL4
        else if (status_first_q[FSWP_S1_SRP] && !wp_n &&
                 !status_config_second_q[FSWP_S2_QE]) // RL5
            sr_write_ok = 1'b0; // RL2
        else if (status_first_q[FSWP_S1_SRP])
            sr_write_ok = status_first_q[FSWP_S1_WEL]; // RL3
    end

    // Framing: opcode byte, then data bytes until chip select rises.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            state_q    <= FSWP_IDLE;
            bit_cnt_q  <= '0;
            shift_q    <= '0;
            opcode_q   <= '0;
            byte_cnt_q <= '0;
            addr_q     <= '0;
        end
        else if (clk_en)
        begin
            case (state_q)
                FSWP_IDLE:
                    if (!cs_n)
                    begin
                        state_q    <= FSWP_CMD;
                        bit_cnt_q  <= '0;
                        byte_cnt_q <= '0;
                    end
                FSWP_CMD, FSWP_DATA, FSWP_SKIP:
                    if (cs_n)
                        state_q <= FSWP_IDLE;
                    else if (sclk_rise)
                    begin
                        shift_q   <= {shift_q[6:0], di};
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (byte_done && state_q == FSWP_CMD)
                        begin
                            opcode_q <= {shift_q[6:0], di};
                            state_q  <= FSWP_DATA;
                        end
                        else if (byte_done)
                        begin
                            if (byte_cnt_q != 5'h1F)
                                byte_cnt_q <= byte_cnt_q + 5'h01;
                            if (byte_cnt_q < 5'h3)
                                addr_q <= {addr_q[FSWP_ADDR_W-9:0],
                                           shift_q[6:0], di};
                        end
                    end
                default:
                    state_q <= FSWP_IDLE;
            endcase
        end
    end

    // Read data shifts out on falling edges, loaded once after the opcode byte and then rotated.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            tx_q      <= '0;
            spi_do    <= 1'b0;
            spi_do_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            spi_do_oe <= (state_q == FSWP_DATA) && !cs_n &&
                         (opcode_q == FSWP_OP_RDSR1 ||
                          opcode_q == FSWP_OP_RDSR2 ||
                          opcode_q == FSWP_OP_RDSR3);
            if (byte_done && state_q == FSWP_CMD)
                tx_q <= ({shift_q[6:0], di} == FSWP_OP_RDSR2) ?
                        status_config_second_q :
                        ({shift_q[6:0], di} == FSWP_OP_RDSR3) ?
                        status_config_third_q : status_first_q;
            else if (sclk_fall && state_q == FSWP_DATA)
            begin
                spi_do <= tx_q[7];
                tx_q   <= {tx_q[6:0], tx_q[7]};
            end
        end
    end

    // Two-byte prefix arms the one-time lock for the next write of the first status byte if only WREN comes between.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            prefix1_q      <= 1'b0;
            prefix_armed_q <= 1'b0;
        end
        else if (clk_en && cmd_end && byte_cnt_q == 5'h0)
        begin
            prefix1_q      <= (opcode_q == FSWP_OP_PREFIX1); // RL6
            prefix_armed_q <= (prefix1_q && opcode_q == FSWP_OP_PREFIX2) ||
                              (prefix_armed_q &&
                               opcode_q == FSWP_OP_WREN); // RL6
        end
        else if (clk_en && cmd_end)
        begin
            prefix1_q      <= 1'b0;
            prefix_armed_q <= 1'b0;
        end
    end

    // One-time lock survives power cycles; only the reset pin of
    // the test fixture clears it.
    always_ff @(posedge core_clk)
    begin
        if (reset)
            otp_lock_q <= 1'b0;
        else if (clk_en && cmd_end && prefix_armed_q && sr_write_ok &&
                 byte_cnt_q != 5'h0 && opcode_q == FSWP_OP_WRSR1)
            otp_lock_q <= 1'b1; // RL6
    end

    assign sus_set = cmd_end && opcode_q == FSWP_OP_SUSPEND && busy_in;
    assign sus_clr = (cmd_end && opcode_q == FSWP_OP_RESUME) ||
                     power_cycle;

    // Status bytes; reserved and status-only bits are masked on write.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            status_first_q         <= FSWP_S1_RESET;
            status_config_second_q <= FSWP_S2_RESET;
            status_config_third_q  <= FSWP_S3_RESET;
        end
        else if (clk_en)
        begin
            if (power_cycle)
                status_config_second_q[FSWP_S2_SRL] <= 1'b0; // RL4
            if (cmd_end && opcode_q == FSWP_OP_WREN)
                status_first_q[FSWP_S1_WEL] <= 1'b1;
            else if (cmd_end && opcode_q == FSWP_OP_WRDI)
                status_first_q[FSWP_S1_WEL] <= 1'b0;
            if (cmd_end && byte_cnt_q != 5'h0 && sr_write_ok)
            begin
                status_first_q[FSWP_S1_WEL] <= 1'b0;
                case (opcode_q)
                    FSWP_OP_WRSR1:
                        status_first_q <= shift_q & FSWP_S1_WMASK; // RL13
                    FSWP_OP_WRSR2:
                        // Lock bits are sticky: OR keeps bits 5:3 and 7 set once set. // RL8
                        status_config_second_q <=
                            (shift_q & FSWP_S2_WMASK) |
                            (status_config_second_q & 8'h38) |
                            (status_config_second_q & 8'h80);
                    FSWP_OP_WRSR3:
                        status_config_third_q <= shift_q & FSWP_S3_WMASK;
                    default:
                        status_first_q[FSWP_S1_WEL] <=
                            status_first_q[FSWP_S1_WEL];
                endcase
            end
            // Set wins over clear when both fall in one cycle.
            if (sus_set)
                status_config_second_q[FSWP_S2_SUS] <= 1'b1; // RL7
            else if (sus_clr)
                status_config_second_q[FSWP_S2_SUS] <= 1'b0; // RL7
            if (array_write_q || array_reject_q)
                status_first_q[FSWP_S1_WEL] <= 1'b0;
            status_first_q[0] <= busy_in;
        end
    end

    // End address of an erase or program for the overlap check.
    always_comb
    begin
        hi_addr = addr_q;
        case (opcode_q)
            FSWP_OP_PP:   hi_addr = addr_q | 23'h0000FF;
            FSWP_OP_SE:   hi_addr = addr_q | 23'h000FFF;
            FSWP_OP_BE64: hi_addr = addr_q | 23'h00FFFF;
            default:      hi_addr = addr_q;
        endcase
    end

    fswp_region u_region
    (
        .block_protect      (status_first_q[FSWP_S1_BP0 +: 3]),
        .sector_granularity (status_first_q[FSWP_S1_SEC]),
        .top_bottom_select  (status_first_q[FSWP_S1_TB]),
        .protect_complement (status_config_second_q[FSWP_S2_CMP]),
        .lo_addr            ((opcode_q == FSWP_OP_CE) ? '0 : addr_q),
        .hi_addr            ((opcode_q == FSWP_OP_CE) ? 23'h7FFFFF : hi_addr),
        .range_protected    (region_prot)
    );

    // Array commands: block locks all start set, so under that scheme
    // every write is refused until an unlock path exists.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            block_locks_q  <= 1'b1; // RL11
            array_write_q  <= 1'b0;
            array_reject_q <= 1'b0;
            array_addr_q   <= '0;
        end
        else if (clk_en)
        begin
            array_write_q  <= 1'b0;
            array_reject_q <= 1'b0;
            if (cmd_end && status_first_q[FSWP_S1_WEL] &&
                (opcode_q == FSWP_OP_CE ||
                 ((opcode_q == FSWP_OP_PP || opcode_q == FSWP_OP_SE ||
                   opcode_q == FSWP_OP_BE64) && byte_cnt_q >= 5'h3)))
            begin
                array_addr_q <= addr_q;
                if (status_config_third_q[FSWP_S3_WPS] ? block_locks_q // RL10
                                                       : region_prot) // RL10
                    array_reject_q <= 1'b1; // RL18
                else
                    array_write_q  <= 1'b1;
            end
        end
    end

    // Decoded controls for the pads and the security area.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            security_lock_q  <= '0;
            quad_data_en_q   <= 1'b0;
            hold_en_q        <= 1'b1;
            drive_strength_q <= FSWP_DRV_RESET; // RL12
        end
        else if (clk_en)
        begin
            security_lock_q  <= status_config_second_q[FSWP_S2_LB1 +: 3];
            quad_data_en_q   <= status_config_second_q[FSWP_S2_QE]; // RL9
            hold_en_q        <= !status_config_second_q[FSWP_S2_QE]; // RL9
            drive_strength_q <= status_config_third_q[FSWP_S3_DRIVE_STRENGTH_LO +: 2];
        end
    end

    // Lock-down must keep bits 7:2 of the first status byte unchanged across a write.
    a_lockdown_hold: assert property (@(posedge core_clk) disable iff (reset)
        (clk_en && status_config_second_q[FSWP_S2_SRL] && !power_cycle)
        |=> $stable(status_first_q[7:2])) // RL4
        else $error("Status changed under lock-down.");

    // Hardware protection refuses writes with pin low outside quad.
    a_pin_refuse: assert property (@(posedge core_clk) disable iff (reset)
        (status_first_q[FSWP_S1_SRP] && !wp_n &&
         !status_config_second_q[FSWP_S2_QE]) |-> !sr_write_ok) // RL2
        else $error("Write accepted with protect pin low.");

    // Without the latch no status write is accepted.
    a_latch_needed: assert property (@(posedge core_clk) disable iff (reset)
        !status_first_q[FSWP_S1_WEL] |-> !sr_write_ok) // RL1
        else $error("Write accepted without latch.");

    // Quad mode makes the pin irrelevant.
    a_quad_pin: assert property (@(posedge core_clk) disable iff (reset)
        (status_config_second_q[FSWP_S2_QE] && !otp_lock_q &&
         !status_config_second_q[FSWP_S2_SRL])
        |-> (sr_write_ok == status_first_q[FSWP_S1_WEL])) // RL5
        else $error("Pin gated a write in quad mode.");

    // Once set, a security lock bit never returns to zero.
    a_lock_sticky: assert property (@(posedge core_clk) disable iff (reset)
        ##1 (status_config_second_q[FSWP_S2_LB1 +: 3] &
             ~$past(status_config_second_q[FSWP_S2_LB1 +: 3])) ==
             (status_config_second_q[FSWP_S2_LB1 +: 3] ^
              $past(status_config_second_q[FSWP_S2_LB1 +: 3]))) // RL8
        else $error("Security lock bit cleared.");

    // Permanent lock forbids any later accept.
    a_otp_final: assert property (@(posedge core_clk) disable iff (reset)
        otp_lock_q |-> !sr_write_ok) // RL6
        else $error("Write accepted after permanent lock.");

    // Suspend sets the flag on the next cycle.
    a_suspend_set: assert property (@(posedge core_clk) disable iff (reset)
        (clk_en && sus_set) |=> status_config_second_q[FSWP_S2_SUS]) // RL7
        else $error("Suspend flag not set.");

    // A protected target never yields an array write pulse.
    a_protect_block: assert property (@(posedge core_clk) disable iff (reset)
        array_write_q |-> !$past(status_config_third_q[FSWP_S3_WPS] ?
                                 block_locks_q : region_prot)) // RL18
        else $error("Write issued into protected region.");

    // Hold and quad data lines are never enabled together.
    a_hold_quad: assert property (@(posedge core_clk) disable iff (reset)
        ##2 (hold_en_q != quad_data_en_q)) // RL9
        else $error("Hold and quad lines both enabled.");

endmodule // fswp_status

// file: fswp_pkg.sv
// Package with constants and types for the flash status write-protect block.
// Notes on behaviour
// (RL1) No protect bits: write needs latch only.
// (RL2) Protect bit, pin low: refuse writes.
// (RL3) Protect bit, pin high: latch enables writes.
// (RL4) Lock-down refuses all writes until power cycle.
// (RL5) Pin gates writes only outside quad mode.
// (RL6) Prefix AAh 55h makes protection permanent.
// (RL7) Suspend flag set by 75h, cleared 7Ah.
// (RL8) Security lock bits only set, never clear.
// (RL9) Quad enable selects data lines over hold.
// (RL10) Scheme select picks bit decode or block locks.
// (RL11) Block locks start locked after any reset.
// (RL12) Two-bit drive strength, default code 11.
// (RL13) Reserved bits ignored on write, read zero.
// (RL14) Block-protect code decodes to protected range.
// (RL15) Sector bit picks 4KB or 64KB units.
// (RL16) Top/bottom bit picks array end.
// (RL17) Complement bit inverts the protected range.
// (RL18) Erase or program touching protection is ignored.
package fswp_pkg;

    // Opcodes recognised by the status logic.
    localparam logic [7:0] FSWP_OP_WREN    = 8'h06;
    localparam logic [7:0] FSWP_OP_WRDI    = 8'h04;
    localparam logic [7:0] FSWP_OP_WRSR1   = 8'h01;
    localparam logic [7:0] FSWP_OP_WRSR2   = 8'h31;
    localparam logic [7:0] FSWP_OP_WRSR3   = 8'h11;
    localparam logic [7:0] FSWP_OP_RDSR1   = 8'h05;
    localparam logic [7:0] FSWP_OP_RDSR2   = 8'h35;
    localparam logic [7:0] FSWP_OP_RDSR3   = 8'h15;
    localparam logic [7:0] FSWP_OP_SUSPEND = 8'h75;
    localparam logic [7:0] FSWP_OP_RESUME  = 8'h7A;
    localparam logic [7:0] FSWP_OP_PREFIX1 = 8'hAA;
    localparam logic [7:0] FSWP_OP_PREFIX2 = 8'h55;
    localparam logic [7:0] FSWP_OP_PP      = 8'h02;
    localparam logic [7:0] FSWP_OP_SE      = 8'h20;
    localparam logic [7:0] FSWP_OP_BE64    = 8'hD8;
    localparam logic [7:0] FSWP_OP_CE      = 8'hC7;

    // Field positions inside the first status byte.
    localparam int FSWP_S1_WEL = 1;
    localparam int FSWP_S1_BP0 = 2;
    localparam int FSWP_S1_TB  = 5;
    localparam int FSWP_S1_SEC = 6;
    localparam int FSWP_S1_SRP = 7;
    // Field positions inside the second status byte.
    localparam int FSWP_S2_SRL = 0;
    localparam int FSWP_S2_QE  = 1;
    localparam int FSWP_S2_LB1 = 3;
    localparam int FSWP_S2_CMP = 6;
    localparam int FSWP_S2_SUS = 7;
    // Field positions inside the third status byte.
    localparam int FSWP_S3_WPS  = 2;
    localparam int FSWP_S3_DRIVE_STRENGTH_LO = 5;

    // Writable masks; reserved and status-only bits are zero.
    localparam logic [7:0] FSWP_S1_WMASK = 8'hFC;
    localparam logic [7:0] FSWP_S2_WMASK = 8'h7B;
    localparam logic [7:0] FSWP_S3_WMASK = 8'h64;

    // Values after reset.
    localparam logic [7:0] FSWP_S1_RESET = 8'h00;
    localparam logic [7:0] FSWP_S2_RESET = 8'h00;
    localparam logic [7:0] FSWP_S3_RESET = 8'h60;
    localparam logic [1:0] FSWP_DRV_RESET = 2'h3;

    // Geometry of the protected array.
    localparam int FSWP_ADDR_W   = 23;
    localparam int FSWP_BLK_W    = 7;
    localparam int FSWP_BLOCKS   = 128;
    localparam int FSWP_SEC_SH   = 12;
    localparam int FSWP_BLK_SH   = 16;
    localparam int FSWP_PAGE_SH  = 8;

    // Command framing states of the link.
    typedef enum logic [1:0]
    {
        FSWP_IDLE = 2'b00,
        FSWP_CMD  = 2'b01,
        FSWP_DATA = 2'b11,
        FSWP_SKIP = 2'b10
    } fswp_state_e;

endpackage

// file: fswp_region.sv
// Decoder of the protect bits into a protected address range.
`timescale 1ns/1ps
module fswp_region
    import fswp_pkg::*;
(
    input  wire logic [2:0]              block_protect,
    input  wire logic                    sector_granularity,
    input  wire logic                    top_bottom_select,
    input  wire logic                    protect_complement,
    input  wire logic [FSWP_ADDR_W-1:0]  lo_addr,
    input  wire logic [FSWP_ADDR_W-1:0]  hi_addr,
    output logic                         range_protected
);

    logic [FSWP_ADDR_W:0] size;
    logic [FSWP_ADDR_W:0] base;
    logic                 lo_in;
    logic                 hi_in;
    logic                 all_in;
    logic                 any_out;

    // Size of the base region; codes 100 to 110 share 32KB in sector mode.
    always_comb
    begin
        size = '0;
        if (block_protect == 3'h7)
            size = 24'h800000; // RL14
        else if (block_protect == 3'h0)
            size = '0; // RL14
        else if (sector_granularity) // RL15
            size = (block_protect[2] ? 24'h008000 :
                    (24'h000800 << block_protect[1:0]));
        else
            size = 24'h010000 << block_protect; // RL14
        base = top_bottom_select ? '0 : (24'h800000 - size); // RL16
    end

    // Overlap test, inverted region test under complement.
    always_comb
    begin
        lo_in  = ({1'b0, lo_addr} >= base) && ({1'b0, lo_addr} < base + size);
        hi_in  = ({1'b0, hi_addr} >= base) && ({1'b0, hi_addr} < base + size);
        all_in = lo_in && hi_in;
        any_out = !all_in;
        // Base region is contiguous at one end, so overlap is end-checks.
        if (protect_complement) // RL17
            range_protected = any_out;
        else if (size == '0)
            range_protected = 1'b0;
        else
            range_protected = lo_in || hi_in ||
                ((lo_addr < base[FSWP_ADDR_W-1:0]) &&
                 ({1'b0, hi_addr} >= base + size));
    end

endmodule // fswp_region

// file: fswp_host_model.sv
// SPI host model that frames status and array instructions.
`timescale 1ns/1ps
module fswp_host_model
(
    input  wire logic core_clk,
    input  wire logic spi_do,
    output logic      spi_clk,
    output logic      spi_cs_n,
    output logic      spi_di
);
    // The link clock is parked low between frames, so it never runs free.
    initial
    begin
        spi_clk  = 1'b0;
        spi_cs_n = 1'b1;
        spi_di   = 1'b0;
    end
    // Ten core cycles make half of the 80 ns link period.
    task automatic half();
        repeat (10) @(negedge core_clk);
    endtask
    // Sends a frame MSB first; the last eight bits seen return in rx.
    task automatic xfer(input logic [39:0] tx, input int nbits,
                        output logic [7:0] rx);
        spi_cs_n = 1'b0;
        for (int i = nbits - 1; i >= 0; i--)
        begin
            spi_di  = tx[i];
            half();
            spi_clk = 1'b1;
            rx      = {rx[6:0], spi_do};
            half();
            spi_clk = 1'b0;
        end
        half();
        spi_cs_n = 1'b1;
        // A released data line must not keep showing the last bit.
        spi_di   = ~spi_di;
        half();
    endtask
endmodule // fswp_host_model

// file: flash_status_write_protect_bench.sv
// Self-checking bench for the status write-protect logic.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    num_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module flash_status_write_protect_bench;
    import fswp_pkg::*;
    logic core_clk, reset, clk_en, power_cycle, spi_clk, spi_cs_n, spi_di;
    logic write_protect_n, busy_in, spi_do, spi_do_oe, quad_data_en_q;
    logic hold_en_q, block_locks_q, array_write_q, array_reject_q;
    logic [7:0] status_first_q, status_config_second_q, status_config_third_q;
    logic [7:0] s1, s2, s3, rx, d;
    logic [2:0] security_lock_q;
    logic [1:0] drive_strength_q;
    logic [FSWP_ADDR_W-1:0] array_addr_q, a;
    logic [15:0] rnd;
    logic write_enable_latch, perm, wr_s, rj_s, e, oe_s;
    int num_errors, comparisons;
    fswp_status i_fswp_status (.core_clk, .reset, .clk_en, .power_cycle,
        .spi_clk, .spi_cs_n, .spi_di, .write_protect_n, .busy_in, .spi_do,
        .spi_do_oe, .status_first_q, .status_config_second_q,
        .status_config_third_q, .security_lock_q, .quad_data_en_q,
        .hold_en_q, .drive_strength_q, .block_locks_q, .array_write_q,
        .array_reject_q, .array_addr_q);
    fswp_host_model i_fswp_host_model (.core_clk, .spi_do, .spi_clk,
        .spi_cs_n, .spi_di);
    // Clock of 4 ns; pulses are caught here since they stand one cycle.
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Sampled mid-cycle, so a pulse is never read in its launch step.
    always @(negedge core_clk)
    begin
        if (array_write_q === 1'b1) wr_s = 1'b1;
        if (array_reject_q === 1'b1) rj_s = 1'b1;
        if (spi_do_oe === 1'b1) oe_s = 1'b1;
    end
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Expected protection of one address from the modelled status bytes.
    function automatic logic prot(input logic [FSWP_ADDR_W-1:0] x);
        logic [FSWP_ADDR_W-1:0] sz;
        logic p;
        sz = s1[6] ? 23'h1000 << (s1[4] ? 3 : s1[4:2] - 1)
                   : 23'h20000 << (s1[4:2] - 1);
        p = s1[5] ? (x < sz) : (x >= ~sz + 23'h1);
        if (s1[4:2] == 3'h0) p = 1'b0;
        if (s1[4:2] == 3'h7) p = 1'b1;
        return (p ^ s2[6]) | s3[2];
    endfunction
    task automatic send(input logic [39:0] tx, input int n);
        i_fswp_host_model.xfer(tx, n, rx);
    endtask
    task automatic wrsr(input logic [7:0] op, input logic [7:0] v);
        send({op, v}, 16);
        if (write_enable_latch && !s2[0] && !perm && (write_protect_n || !s1[7] || s2[1]))
        begin
            write_enable_latch = 1'b0;
            if (op == FSWP_OP_WRSR1) s1 = v & 8'hFC;
            else if (op == FSWP_OP_WRSR2) s2 = v & 8'h7B | s2 & 8'hB8;
            else s3 = v & 8'h64;
        end
    endtask
    task automatic wren();
        send(FSWP_OP_WREN, 8);
        write_enable_latch = 1'b1;
    endtask
    // Compares every visible status field, also through a status read.
    task automatic check();
        `CHK("s1", {s1[7:2], write_enable_latch, busy_in}, status_first_q)
        `CHK("s2", s2, status_config_second_q)
        `CHK("s3", s3, status_config_third_q)
        `CHK("lock", s2[5:3], security_lock_q)
        `CHK("quad", s2[1], quad_data_en_q)
        `CHK("hold", ~s2[1], hold_en_q)
        `CHK("drv", s3[6:5], drive_strength_q)
        oe_s = 1'b0;
        send({FSWP_OP_RDSR2, 8'h00}, 16);
        `CHK("rd2", s2, rx)
        `CHK("oe", 1'b1, oe_s)
    endtask
    task automatic pulse_power();
        @(negedge core_clk) power_cycle = 1'b1;
        @(negedge core_clk) power_cycle = 1'b0;
        repeat (4) @(negedge core_clk);
        s2[0] = 1'b0;
        s2[7] = 1'b0;
    endtask
    task automatic report_and_stop();
        if (num_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // The whole run needs about 44000 cycles; this margin cuts a hang.
    initial
    begin
        repeat (90000) @(posedge core_clk);
        num_errors++;
        report_and_stop();
    end
    initial
    begin
        {num_errors, comparisons} = 0;
        {reset, clk_en, power_cycle, write_protect_n, busy_in} = 5'b11010;
        {s1, s2, s3, write_enable_latch, perm, rnd} = {16'h0000, 8'h60, 2'b00, 16'hFF8A};
        repeat (12) @(negedge core_clk);
        reset = 1'b0;
        repeat (4) @(negedge core_clk);
        `CHK("blk", 1'b1, block_locks_q)
        check();
        wrsr(FSWP_OP_WRSR2, 8'h02);
        check();
        for (int i = 0; i < 40; i++)
        begin
            rnd = nx(rnd);
            d = rnd[15:8];
            write_protect_n = rnd[0];
            if (d[6] && d[4:2] == 3'h6) d[3] = 1'b0;
            if (rnd[1]) wren();
            if (rnd[3:2] == 2'h0) wrsr(FSWP_OP_WRSR1, d);
            if (rnd[3:2] == 2'h1) wrsr(FSWP_OP_WRSR2, d & 8'hFE);
            if (rnd[3:2] == 2'h2) wrsr(FSWP_OP_WRSR3, d);
            if (rnd[3:2] == 2'h3)
            begin
                a = {rnd[14:0], rnd[15:8] ^ rnd[7:0]};
                e = prot(a);
                wren();
                {wr_s, rj_s} = 2'b00;
                send({FSWP_OP_PP, 1'b0, a, d}, 40);
                `CHK("arr", {~e, e}, {wr_s, rj_s})
                if (!e) `CHK("addr", a, array_addr_q)
                send(FSWP_OP_WRDI, 8);
                write_enable_latch = 1'b0;
            end
            check();
        end
        busy_in = 1'b1;
        send(FSWP_OP_SUSPEND, 8);
        s2[7] = 1'b1;
        check();
        send(FSWP_OP_RESUME, 8);
        s2[7] = 1'b0;
        check();
        send(FSWP_OP_SUSPEND, 8);
        {busy_in, s2[7], write_protect_n} = 3'b011;
        wren();
        wrsr(FSWP_OP_WRSR2, s2 | 8'h01);
        wren();
        wrsr(FSWP_OP_WRSR3, ~s3);
        check();
        pulse_power();
        check();
        send(FSWP_OP_PREFIX1, 8);
        send(FSWP_OP_PREFIX2, 8);
        wren();
        send({FSWP_OP_WRSR1, s1}, 16);
        send(FSWP_OP_WRDI, 8);
        {write_enable_latch, perm} = 2'b01;
        pulse_power();
        wren();
        // A frame sent while frozen must leave the latch as it was.
        clk_en = 1'b0;
        send(FSWP_OP_WRDI, 8);
        clk_en = 1'b1;
        wrsr(FSWP_OP_WRSR3, ~s3);
        check();
        report_and_stop();
    end
endmodule // flash_status_write_protect_bench
